// File: hw/eeprom_slave_pkg.sv
// Constants and types shared by the two-wire memory slave
package eeprom_slave_pkg;

   // Clock rates of the two domains
   localparam int CLOCK_PERIOD_NS       = 10;
   localparam int LINK_CLOCK_PERIOD_NS  = 6;

   // Input glitch suppression, pulses up to this width are ignored
   localparam int GLITCH_FILTER_WIDTH_NS = 100;
   // One sample beyond the width, so a full-width pulse never gets through
   localparam int GLITCH_FILTER_CYCLES   = GLITCH_FILTER_WIDTH_NS / LINK_CLOCK_PERIOD_NS + 2;

   // Self-timed program cycle, longest time rounded down
   localparam int PROGRAM_CYCLE_TIME_MS   = 5;
   localparam int PROGRAM_CYCLE_COUNT     = PROGRAM_CYCLE_TIME_MS * 1000000 / CLOCK_PERIOD_NS;

   // Readiness after reset, longest time rounded down
   localparam int POWERUP_TO_WRITE_DELAY_MS = 1;
   localparam int POWERUP_CYCLE_COUNT       = POWERUP_TO_WRITE_DELAY_MS * 1000000 / CLOCK_PERIOD_NS;

   // Width of the long cycle counters
   localparam int TIMER_WIDTH = 20;

   // Memory organisation
   localparam int MEM_ADDR_WIDTH = 14;
   localparam int MEM_DEPTH      = 16384;

   // Fixed upper nibble of the slave address byte
   localparam logic [3:0] SLAVE_PREFIX = 4'ha;

   // Byte positions within a transfer
   localparam logic [1:0] BYTE_SLAVE   = 2'h0;
   localparam logic [1:0] BYTE_ADDR_HI = 2'h1;
   localparam logic [1:0] BYTE_ADDR_LO = 2'h2;
   localparam logic [1:0] BYTE_DATA    = 2'h3;

   // Bits in one byte before the ninth clock
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Link-side protocol states
   typedef enum logic [5:0] {
      LS_IDLE = 6'b000001,
      LS_RECV = 6'b000010,
      LS_ACK  = 6'b000100,
      LS_SEND = 6'b001000,
      LS_MACK = 6'b010000,
      LS_WAIT = 6'b100000
   } link_state_t;

endpackage

// File: hw/glitch_filter.sv
// Two-flop synchroniser followed by a pulse-width filter for one bus line
`timescale 1ns/1ns
module glitch_filter
   import eeprom_slave_pkg::*;
#(
   parameter int CYCLES = GLITCH_FILTER_CYCLES
) (
   input  logic link_clock,
   input  logic rst_n,
   input  logic enable,
   input  logic raw,
   output logic filtered
);

   localparam int CNT_W = $clog2(CYCLES + 1);

   logic             sync_a_reg;
   logic             sync_b_reg;
   logic [CNT_W-1:0] count_reg;

   // Bring the pin into the link domain, idle bus reads high
   always_ff @(posedge link_clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_a_reg <= 1'b1;
         sync_b_reg <= 1'b1;
      end else if (enable) begin
         sync_a_reg <= raw;
         sync_b_reg <= sync_a_reg;
      end
   end

   // Accept a new level only after it stays put longer than the glitch width
   always_ff @(posedge link_clock or negedge rst_n) begin
      if (!rst_n) begin
         filtered  <= 1'b1;
         count_reg <= '0;
      end else if (enable) begin
         if (sync_b_reg == filtered) begin
            count_reg <= '0;
         end else if (count_reg == CNT_W'(CYCLES - 1)) begin
            filtered  <= sync_b_reg;
            count_reg <= '0;
         end else begin
            count_reg <= count_reg + CNT_W'(1);
         end
      end
   end

endmodule

// File: hw/pulse_crossing.sv
// Toggle-based crossing of a one-cycle event between two clock domains
`timescale 1ns/1ns
module pulse_crossing (
   input  logic src_clock,
   input  logic dst_clock,
   input  logic rst_n,
   input  logic src_enable,
   input  logic dst_enable,
   input  logic src_pulse,
   output logic dst_pulse
);

   logic toggle_reg;
   logic sync_a_reg;
   logic sync_b_reg;
   logic sync_c_reg;

   // Each source event flips the toggle
   always_ff @(posedge src_clock or negedge rst_n) begin
      if (!rst_n) begin
         toggle_reg <= 1'b0;
      end else if (src_enable && src_pulse) begin
         toggle_reg <= ~toggle_reg;
      end
   end

   // Synchronise the toggle and keep one more stage for the edge
   always_ff @(posedge dst_clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_a_reg <= 1'b0;
         sync_b_reg <= 1'b0;
         sync_c_reg <= 1'b0;
      end else if (dst_enable) begin
         sync_a_reg <= toggle_reg;
         sync_b_reg <= sync_a_reg;
         sync_c_reg <= sync_b_reg;
      end
   end

   // One destination cycle per source event
   assign dst_pulse = sync_b_reg ^ sync_c_reg;

endmodule

// File: hw/eeprom_slave.sv
// Two-wire slave front end with byte write, program timer and memory array
`timescale 1ns/1ns
module eeprom_slave
   import eeprom_slave_pkg::*;
#(
   parameter int PROGRAM_CYCLES = PROGRAM_CYCLE_COUNT,
   parameter int POWERUP_CYCLES = POWERUP_CYCLE_COUNT
) (
   input  logic       clock,
   input  logic       rst_n,
   input  logic       clock_enable,
   input  logic       link_clock,
   input  logic       scl_in,
   input  logic       sda_in,
   output logic       sda_out,
   output logic       sda_oe,
   input  logic [2:0] chip_select_straps,
   input  logic       write_guard,
   output logic       program_busy,
   output logic       device_ready
);

   // ---------------- Core domain state ----------------
   logic [7:0]             mem [MEM_DEPTH];
   logic [7:0]             rd_data_reg;
   logic [TIMER_WIDTH-1:0] powerup_cnt_reg;
   logic [TIMER_WIDTH-1:0] program_cnt_reg;
   logic                   busy_level_reg;
   logic                   done_fire_reg;
   logic                   core_req;

   // ---------------- Link domain state ----------------
   link_state_t               state_reg;
   logic                      link_en_a_reg;
   logic                      link_en;
   logic [2:0]                strap_a_reg;
   logic [2:0]                strap_b_reg;
   logic                      guard_a_reg;
   logic                      guard_b_reg;
   logic                      busy_a_reg;
   logic                      busy_b_reg;
   logic                      scl_f;
   logic                      sda_f;
   logic                      scl_d_reg;
   logic                      sda_d_reg;
   logic                      start_det;
   logic                      stop_det;
   logic                      scl_rise;
   logic                      scl_fall;
   logic [3:0]                bit_cnt_reg;
   logic [1:0]                byte_cnt_reg;
   logic [7:0]                shift_reg;
   logic [7:0]                tx_reg;
   logic [7:0]                next_byte_reg;
   logic                      read_mode_reg;
   logic [MEM_ADDR_WIDTH-1:0] ptr_reg;
   logic [7:0]                wdata_reg;
   logic                      write_pending_reg;
   logic                      req_fire_reg;
   logic                      req_write_reg;
   logic [MEM_ADDR_WIDTH-1:0] req_addr_reg;
   logic [7:0]                req_data_reg;
   logic                      outstanding_reg;
   logic                      link_done;
   logic                      addr_match;

   // Open drain: the line is only ever pulled low
   // open drain
   assign sda_out = 1'b0;

   // Freeze control carried into the link domain
   always_ff @(posedge link_clock or negedge rst_n) begin
      if (!rst_n) begin
         link_en_a_reg <= 1'b0;
         link_en       <= 1'b0;
      end else begin
         link_en_a_reg <= clock_enable;
         link_en       <= link_en_a_reg;
      end
   end

   // Straps, write guard and busy level into the link domain
   // strap sampling
   always_ff @(posedge link_clock or negedge rst_n) begin
      if (!rst_n) begin
         strap_a_reg <= 3'h0;
         strap_b_reg <= 3'h0;
         guard_a_reg <= 1'b0;
         guard_b_reg <= 1'b0;
         busy_a_reg  <= 1'b1;
         busy_b_reg  <= 1'b1;
      end else if (link_en) begin
         strap_a_reg <= chip_select_straps;
         strap_b_reg <= strap_a_reg;
         guard_a_reg <= write_guard;
         guard_b_reg <= guard_a_reg;
         busy_a_reg  <= busy_level_reg;
         busy_b_reg  <= busy_a_reg;
      end
   end

   glitch_filter #(.CYCLES(GLITCH_FILTER_CYCLES)) scl_filter (
      .link_clock (link_clock),
      .rst_n      (rst_n),
      .enable     (link_en),
      .raw        (scl_in),
      .filtered   (scl_f)
   );

   glitch_filter #(.CYCLES(GLITCH_FILTER_CYCLES)) sda_filter (
      .link_clock (link_clock),
      .rst_n      (rst_n),
      .enable     (link_en),
      .raw        (sda_in),
      .filtered   (sda_f)
   );

   // Previous filtered levels for edge detection
   always_ff @(posedge link_clock or negedge rst_n) begin
      if (!rst_n) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else if (link_en) begin
         scl_d_reg <= scl_f;
         sda_d_reg <= sda_f;
      end
   end

   assign start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
   assign stop_det  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
   assign scl_rise  = scl_f & ~scl_d_reg;
   assign scl_fall  = ~scl_f & scl_d_reg;

   assign addr_match = (shift_reg[7:4] == SLAVE_PREFIX) && (shift_reg[3:1] == strap_b_reg)
                       && !busy_b_reg && !outstanding_reg;

   // Protocol engine
   always_ff @(posedge link_clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg         <= LS_IDLE;
         bit_cnt_reg       <= 4'h0;
         byte_cnt_reg      <= BYTE_SLAVE;
         shift_reg         <= 8'h00;
         tx_reg            <= 8'h00;
         read_mode_reg     <= 1'b0;
         ptr_reg           <= '0;
         wdata_reg         <= 8'h00;
         write_pending_reg <= 1'b0;
         req_fire_reg      <= 1'b0;
         req_write_reg     <= 1'b0;
         req_addr_reg      <= '0;
         req_data_reg      <= 8'h00;
         sda_oe            <= 1'b0;
      end else if (link_en) begin
         req_fire_reg <= 1'b0;
         if (stop_det) begin
            state_reg         <= LS_IDLE;
            sda_oe            <= 1'b0;
            write_pending_reg <= 1'b0;
            if (write_pending_reg) begin
               req_fire_reg  <= 1'b1;
               req_write_reg <= 1'b1;
               req_addr_reg  <= ptr_reg;
               req_data_reg  <= wdata_reg;
               ptr_reg       <= ptr_reg + MEM_ADDR_WIDTH'(1);
            end
         end else if (start_det) begin
            state_reg         <= LS_RECV;
            bit_cnt_reg       <= 4'h0;
            byte_cnt_reg      <= BYTE_SLAVE;
            read_mode_reg     <= 1'b0;
            write_pending_reg <= 1'b0;
            sda_oe            <= 1'b0;
         end else begin
            unique case (state_reg)
               LS_IDLE, LS_WAIT: begin
                  sda_oe <= 1'b0;
               end
               LS_RECV: begin
                  if (scl_rise) begin
                     shift_reg   <= {shift_reg[6:0], sda_f};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
                     bit_cnt_reg <= 4'h0;
                     if (byte_cnt_reg != BYTE_DATA) begin
                        byte_cnt_reg <= byte_cnt_reg + 2'h1;
                     end
                     state_reg <= LS_ACK;
                     sda_oe    <= 1'b1;
                     unique case (byte_cnt_reg)
                        BYTE_SLAVE: begin
                           if (addr_match) begin
                              read_mode_reg <= shift_reg[0];
                              if (shift_reg[0]) begin
                                 req_fire_reg  <= 1'b1;
                                 req_write_reg <= 1'b0;
                                 req_addr_reg  <= ptr_reg;
                              end
                           end else begin
                              state_reg <= LS_WAIT;
                              sda_oe    <= 1'b0;
                           end
                        end
                        BYTE_ADDR_HI: ptr_reg[MEM_ADDR_WIDTH-1:8] <= shift_reg[MEM_ADDR_WIDTH-9:0];
                        BYTE_ADDR_LO: ptr_reg[7:0] <= shift_reg;
                        BYTE_DATA: begin
                           if (guard_b_reg) begin
                              state_reg         <= LS_WAIT;
                              sda_oe            <= 1'b0;
                              write_pending_reg <= 1'b0;
                           end else begin
                              wdata_reg         <= shift_reg;
                              write_pending_reg <= 1'b1;
                           end
                        end
                     endcase
                  end
               end
               LS_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (read_mode_reg) begin
                        state_reg   <= LS_SEND;
                        sda_oe      <= ~next_byte_reg[7];
                        tx_reg      <= {next_byte_reg[6:0], 1'b0};
                        bit_cnt_reg <= 4'h1;
                     end else begin
                        state_reg <= LS_RECV;
                        sda_oe    <= 1'b0;
                     end
                  end
               end
               LS_SEND: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg == BITS_PER_BYTE) begin
                        state_reg   <= LS_MACK;
                        sda_oe      <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                     end else begin
                        sda_oe      <= ~tx_reg[7];
                        tx_reg      <= {tx_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               end
               LS_MACK: begin
                  if (scl_rise) begin
                     ptr_reg <= ptr_reg + MEM_ADDR_WIDTH'(1);
                     if (!sda_f) begin
                        req_fire_reg  <= 1'b1;
                        req_write_reg <= 1'b0;
                        req_addr_reg  <= ptr_reg + MEM_ADDR_WIDTH'(1);
                        state_reg     <= LS_ACK;
                     end else begin
                        state_reg <= LS_WAIT;
                     end
                  end
               end
               default: begin
                  state_reg <= LS_IDLE;
                  sda_oe    <= 1'b0;
               end
            endcase
         end
      end
   end

   // Request in flight; new selection is not acknowledged until it completes
   // ignore during transfer
   always_ff @(posedge link_clock or negedge rst_n) begin
      if (!rst_n) begin
         outstanding_reg <= 1'b0;
      end else if (link_en) begin
         if (req_fire_reg) begin
            outstanding_reg <= 1'b1;
         end else if (link_done) begin
            outstanding_reg <= 1'b0;
         end
      end
   end

   // Read byte returned from the core, held until next answer
   always_ff @(posedge link_clock or negedge rst_n) begin
      if (!rst_n) begin
         next_byte_reg <= 8'hff;
      end else if (link_en && link_done) begin
         next_byte_reg <= rd_data_reg;
      end
   end

   // Request event into the core domain; fields held stable meanwhile
   pulse_crossing req_crossing (
      .src_clock  (link_clock),
      .dst_clock  (clock),
      .rst_n      (rst_n),
      .src_enable (link_en),
      .dst_enable (clock_enable),
      .src_pulse  (req_fire_reg),
      .dst_pulse  (core_req)
   );

   // Completion event back into the link domain
   pulse_crossing done_crossing (
      .src_clock  (clock),
      .dst_clock  (link_clock),
      .rst_n      (rst_n),
      .src_enable (clock_enable),
      .dst_enable (link_en),
      .src_pulse  (done_fire_reg),
      .dst_pulse  (link_done)
   );

   // Memory access on each request
   always_ff @(posedge clock) begin
      if (clock_enable && core_req) begin
         if (req_write_reg) begin
            mem[req_addr_reg] <= req_data_reg;
         end else begin
            rd_data_reg <= mem[req_addr_reg];
         end
      end
   end

   // Answer one cycle after the request is served
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         done_fire_reg <= 1'b0;
      end else if (clock_enable) begin
         done_fire_reg <= core_req;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         powerup_cnt_reg <= '0;
         device_ready    <= 1'b0;
      end else if (clock_enable && !device_ready) begin
         if (powerup_cnt_reg == TIMER_WIDTH'(POWERUP_CYCLES - 1)) begin
            device_ready <= 1'b1;
         end else begin
            powerup_cnt_reg <= powerup_cnt_reg + TIMER_WIDTH'(1);
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         program_cnt_reg <= '0;
         program_busy    <= 1'b0;
      end else if (clock_enable) begin
         if (core_req && req_write_reg) begin
            program_busy    <= 1'b1;
            program_cnt_reg <= '0;
         end else if (program_busy) begin
            if (program_cnt_reg == TIMER_WIDTH'(PROGRAM_CYCLES - 1)) begin
               program_busy <= 1'b0;
            end else begin
               program_cnt_reg <= program_cnt_reg + TIMER_WIDTH'(1);
            end
         end
      end
   end

   // Busy level seen by the link: set with the write, before its answer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_level_reg <= 1'b1;
      end else if (clock_enable) begin
         busy_level_reg <= (program_busy && !(program_cnt_reg == TIMER_WIDTH'(PROGRAM_CYCLES - 1)))
                           || (core_req && req_write_reg) || !device_ready;
      end
   end

endmodule

// File: verif/eeprom_slave_asserts.sv
// Port checks for the two-wire memory slave
`timescale 1ns/1ns
module eeprom_slave_asserts
   import eeprom_slave_pkg::*;
#(
   parameter int PROGRAM_CYCLES = PROGRAM_CYCLE_COUNT,
   parameter int POWERUP_CYCLES = POWERUP_CYCLE_COUNT
) (
   input logic       clock,
   input logic       rst_n,
   input logic       clock_enable,
   input logic       link_clock,
   input logic       scl_in,
   input logic       sda_in,
   input logic       sda_out,
   input logic       sda_oe,
   input logic [2:0] chip_select_straps,
   input logic       write_guard,
   input logic       program_busy,
   input logic       device_ready
);
   logic [TIMER_WIDTH-1:0] busy_len;
   logic [TIMER_WIDTH-1:0] up_len;
   // Cycles in program cycle and since reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy_len <= '0;
         up_len   <= '0;
      end else begin
         busy_len <= program_busy ? busy_len + 1'b1 : '0;
         up_len   <= (&up_len) ? up_len : up_len + 1'b1;
      end
   end
   sequence s_busy_start;
      !program_busy ##1 program_busy;
   endsequence
   property p_open_drain;
      @(posedge clock) disable iff (!rst_n) sda_out == 1'b0;
   endproperty
   property p_busy_hold;
      @(posedge clock) disable iff (!rst_n) s_busy_start |-> program_busy [*8];
   endproperty
   property p_busy_len;
      @(posedge clock) disable iff (!rst_n)
         $fell(program_busy) |-> busy_len >= PROGRAM_CYCLES - 1 && busy_len <= PROGRAM_CYCLES + 1;
   endproperty
   property p_busy_silent;
      @(posedge clock) disable iff (!rst_n) program_busy |-> !sda_oe;
   endproperty
   property p_quiet_unready;
      @(posedge clock) disable iff (!rst_n) !device_ready |-> !sda_oe;
   endproperty
   property p_ready_in_time;
      @(posedge clock) disable iff (!rst_n) up_len > POWERUP_CYCLES + 4 |-> device_ready;
   endproperty
   property p_guard_blocks;
      @(posedge clock) disable iff (!rst_n) $rose(program_busy) |-> !write_guard;
   endproperty
   property p_oe_scl_low;
      @(posedge link_clock) disable iff (!rst_n) $changed(sda_oe) |-> !scl_in;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("data output not low");
   a_busy_hold: assert property (p_busy_hold)
      else $error("program cycle too short");
   a_busy_len: assert property (p_busy_len)
      else $error("program cycle length wrong");
   a_busy_silent: assert property (p_busy_silent)
      else $error("data pulled while programming");
   a_quiet_unready: assert property (p_quiet_unready)
      else $error("data pulled before ready");
   a_ready_in_time: assert property (p_ready_in_time)
      else $error("ready too late");
   a_guard_blocks: assert property (p_guard_blocks)
      else $error("programming while guarded");
   a_oe_scl_low: assert property (p_oe_scl_low)
      else $error("data changed with clock high");
endmodule
bind eeprom_slave eeprom_slave_asserts #(.PROGRAM_CYCLES(PROGRAM_CYCLES), .POWERUP_CYCLES(POWERUP_CYCLES)) u_asserts (
   .clock(clock), .rst_n(rst_n), .clock_enable(clock_enable), .link_clock(link_clock), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_straps(chip_select_straps),
   .write_guard(write_guard), .program_busy(program_busy), .device_ready(device_ready));

// File: verif/i2c_master_model.sv
// Behavioural bus master driving the clock line and pulling the data line
`timescale 1ns/1ns
module i2c_master_model (
   output logic scl,
   output logic sda_low,
   input  logic sda_line
);
   int glitch_ns = 0;
   // Idle bus, both lines released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic start();
      #300 sda_low = 1'b0;
      #1000 scl = 1'b1;
      #700 sda_low = 1'b1;
      #700 scl = 1'b0;
   endtask
   task automatic stop();
      #300 sda_low = 1'b1;
      #1000 scl = 1'b1;
      #700 sda_low = 1'b0;
      #1300;
   endtask
   // data moves only with clock low, except the short pulse driven with clock high when glitch_ns is set
   task automatic bit_io(input logic b, output logic r);
      int g;
      g = glitch_ns;
      glitch_ns = 0;
      #300 sda_low = !b;
      if (g > 0) begin
         #400 scl = 1'b1;
         #(g) scl = 1'b0;
      end
      #1000 scl = 1'b1;
      #350 r = sda_line;
      // short data pulse with clock high is no START or STOP
      if (g > 0) begin
         sda_low = b;
         #(g) sda_low = !b;
      end
      #350 scl = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(!ack, r);
   endtask
endmodule

// File: verif/test_i2c_eeprom_slave_byte_write.sv
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ns
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
   $display("[ERR] %0t got %h want %h", $time, got, exp); end end
module test_i2c_eeprom_slave_byte_write;
   import eeprom_slave_pkg::*;
   logic       clock = 1'b0;
   logic       link_clock = 1'b0;
   logic       rst_n = 1'b0;
   logic       clock_enable = 1'b1;
   logic [2:0] chip_select_straps = 3'h0;
   logic       write_guard = 1'b0;
   logic       sda_out;
   logic       sda_oe;
   logic       program_busy;
   logic       device_ready;
   logic       scl;
   logic       sda_low;
   wire        sda_line = sda_oe ? sda_out : !sda_low;
   int         bad_count = 0;
   int         n_compared = 0;
   always #5 clock = ~clock;
   // Link clock with its own phase
   initial begin
      #1;
      forever #3 link_clock = ~link_clock;
   end
   eeprom_slave #(.PROGRAM_CYCLES(3000), .POWERUP_CYCLES(50)) dut (
      .clock(clock), .rst_n(rst_n), .clock_enable(clock_enable), .link_clock(link_clock), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_straps(chip_select_straps),
      .write_guard(write_guard), .program_busy(program_busy), .device_ready(device_ready));
   i2c_master_model master (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wait_for(input logic ready_wait, input int limit);
      int n = 0;
      while ((ready_wait ? device_ready !== 1'b1 : program_busy !== 1'b0) && n < limit) begin
         @(negedge clock);
         n++;
      end
      if (n >= limit) begin
         bad_count++;
         $display("[ERR] %0t wait ran out", $time);
         results();
      end
   endtask
   function automatic logic [3:0] exp_acks(input logic [2:0] sel, input logic guard);
      return (sel == chip_select_straps) ? (guard ? 4'he : 4'hf) : 4'h0;
   endfunction
   task automatic write_op(input logic [2:0] sel, input logic [15:0] ptr, input logic [7:0] d,
                           input logic rd, output logic [3:0] acks);
      master.start();
      master.send_byte({SLAVE_PREFIX, sel, 1'b0}, acks[3]);
      master.send_byte(ptr[15:8], acks[2]);
      master.send_byte(ptr[7:0], acks[1]);
      if (rd) begin
         master.start();
         master.send_byte({SLAVE_PREFIX, sel, 1'b1}, acks[0]);
      end else master.send_byte(d, acks[0]);
   endtask
   initial begin
      logic [3:0]  acks;
      logic [7:0]  d;
      logic [7:0]  rd;
      logic [7:0]  stored;
      logic [15:0] ptr;
      logic        a;
      void'($urandom(4342));
      chip_select_straps = 3'($urandom());
      repeat (2) @(posedge clock);
      @(negedge clock) rst_n = 1'b1;
      wait_for(1'b1, 80);
      write_op(chip_select_straps ^ 3'h5, 16'h0000, 8'h00, 1'b0, acks);
      master.stop();
      `CHECK(acks, 4'h0)
      for (int i = 0; i < 3; i++) begin
         if (i != 1) begin
            ptr = (i == 2) ? 16'hffff : 16'($urandom());
            d = 8'($urandom());
         end else d = ~d;
         write_guard = (i == 1);
         master.glitch_ns = (i == 0) ? 60 : 0;
         write_op(chip_select_straps, ptr, d, 1'b0, acks);
         master.stop();
         `CHECK(acks, exp_acks(chip_select_straps, write_guard))
         if (!write_guard) stored = d;
         repeat (30) @(negedge clock);
         `CHECK(program_busy, !write_guard)
         if (!write_guard) begin
            master.start();
            master.send_byte({SLAVE_PREFIX, chip_select_straps, 1'b0}, a);
            master.stop();
            `CHECK(a, 1'b0)
         end
         wait_for(1'b0, 3200);
         write_guard = 1'b0;
         write_op(chip_select_straps, ptr ^ 16'hc000, 8'h00, 1'b1, acks);
         master.recv_byte(1'b0, rd);
         master.stop();
         `CHECK(acks, 4'hf)
         `CHECK(rd, stored)
      end
      results();
   end
   // Cut a hung run short
   initial begin
      #990000;
      bad_count++;
      results();
   end
endmodule
